// ### hw/mlic_pkg.sv
// shared constants and carrier types of the interrupt controller
package mlic_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int VEC_W = 17;
  localparam int MAP_W = 8;
  localparam int OFS_W = 4;
  localparam int PER_W = 5;

  // ---------------------------------------------------------------
  // levels
  // ---------------------------------------------------------------
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_MED  = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_OFF  = 2'h3;
  localparam int         NUM_LVL  = 3;

  // ---------------------------------------------------------------
  // vector map, program word addresses
  // ---------------------------------------------------------------
  localparam logic [MAP_W-1:0] reset_vector           = 8'h00;
  localparam logic [MAP_W-1:0] osc_fail_vector        = 8'h02;
  localparam logic [MAP_W-1:0] port_c_irq_base        = 8'h04;
  localparam logic [MAP_W-1:0] port_r_irq_base        = 8'h08;
  localparam logic [MAP_W-1:0] real_time_irq_base     = 8'h14;
  localparam logic [MAP_W-1:0] two_wire_c_irq_base    = 8'h18;
  localparam logic [MAP_W-1:0] timer_c_type0_irq_base = 8'h1c;
  localparam logic [MAP_W-1:0] timer_c_type1_irq_base = 8'h28;
  localparam logic [MAP_W-1:0] serial_periph_c_vector = 8'h30;
  localparam logic [MAP_W-1:0] serial_c_irq_base      = 8'h32;
  localparam logic [MAP_W-1:0] nonvolatile_irq_base   = 8'h40;
  localparam logic [MAP_W-1:0] port_b_irq_base        = 8'h44;
  localparam logic [MAP_W-1:0] port_e_irq_base        = 8'h56;
  localparam logic [MAP_W-1:0] two_wire_e_irq_base    = 8'h5a;
  localparam logic [MAP_W-1:0] timer_e_type0_irq_base = 8'h5e;
  localparam logic [MAP_W-1:0] serial_e_irq_base      = 8'h74;
  localparam logic [MAP_W-1:0] port_d_irq_base        = 8'h80;
  localparam logic [MAP_W-1:0] port_a_irq_base        = 8'h84;
  localparam logic [MAP_W-1:0] comparator_irq_base    = 8'h88;
  localparam logic [MAP_W-1:0] converter_irq_base     = 8'h8e;
  localparam logic [MAP_W-1:0] timer_d_type0_irq_base = 8'h9a;
  localparam logic [MAP_W-1:0] serial_periph_d_vector = 8'hae;
  localparam logic [MAP_W-1:0] serial_d_irq_base      = 8'hb0;
  localparam logic [MAP_W-1:0] port_f_irq_base        = 8'hd0;
  localparam logic [MAP_W-1:0] timer_f_type0_irq_base = 8'hd8;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [VEC_W-1:0] BOOT_BASE_RST = 17'h1_0000;

  // ---------------------------------------------------------------
  // peripherals owning a map entry
  // ---------------------------------------------------------------
  typedef enum logic [PER_W-1:0] {
    PER_PORT_C, PER_PORT_R, PER_RTC, PER_TWI_C, PER_TMR_C0,
    PER_TMR_C1, PER_SPI_C, PER_USART_C, PER_NVM, PER_PORT_B,
    PER_PORT_E, PER_TWI_E, PER_TMR_E0, PER_USART_E, PER_PORT_D,
    PER_PORT_A, PER_COMP, PER_ADC, PER_TMR_D0, PER_SPI_D,
    PER_USART_D, PER_PORT_F, PER_TMR_F0
  } mlic_periph_t;

  typedef struct packed {
    logic [1:0]       level;
    mlic_periph_t     periph;
    logic [OFS_W-1:0] offset;
  } mlic_src_cfg_t;

  typedef struct packed {
    logic             nmi;
    logic [1:0]       level;
    logic [VEC_W-1:0] addr;
  } mlic_grant_t;

endpackage

// ### hw/mlic_top.sv
// multi-level interrupt controller: ranking, preemption, vectoring
`timescale 1ns/1ps

module mlic_top #(
  parameter int                        NSRC      = 16,
  parameter logic [mlic_pkg::VEC_W-1:0] BOOT_BASE =
    mlic_pkg::BOOT_BASE_RST
) (
  input  wire logic                   clock_in,
  input  wire logic                   rst_n_in,
  input  wire logic [NSRC-1:0]        src_req_in,
  input  wire mlic_pkg::mlic_src_cfg_t src_cfg_in [NSRC],
  input  wire logic [2:0]             level_en_in,
  input  wire logic                   rr_en_in,
  input  wire logic                   vec_boot_in,
  input  wire logic                   osc_fail_in,
  input  wire logic                   ack_in,
  input  wire logic                   reti_in,
  output logic                        irq_out,
  output mlic_pkg::mlic_grant_t       grant_out,
  output logic [NSRC-1:0]             ack_src_out,
  output logic [3:0]                  active_out
);
  import mlic_pkg::*;

  localparam int IDX_W = (NSRC > 1) ? $clog2(NSRC) : 1;

  // ---------------------------------------------------------------
  // vector map lookup
  // ---------------------------------------------------------------
  function automatic logic [MAP_W-1:0] periph_base(mlic_periph_t p);
    logic [MAP_W-1:0] b;
    b = port_c_irq_base;
    unique case (p)
      PER_PORT_C:  b = port_c_irq_base;
      PER_PORT_R:  b = port_r_irq_base;
      PER_RTC:     b = real_time_irq_base;
      PER_TWI_C:   b = two_wire_c_irq_base;
      PER_TMR_C0:  b = timer_c_type0_irq_base;
      PER_TMR_C1:  b = timer_c_type1_irq_base;
      PER_SPI_C:   b = serial_periph_c_vector;
      PER_USART_C: b = serial_c_irq_base;
      PER_NVM:     b = nonvolatile_irq_base;
      PER_PORT_B:  b = port_b_irq_base;
      PER_PORT_E:  b = port_e_irq_base;
      PER_TWI_E:   b = two_wire_e_irq_base;
      PER_TMR_E0:  b = timer_e_type0_irq_base;
      PER_USART_E: b = serial_e_irq_base;
      PER_PORT_D:  b = port_d_irq_base;
      PER_PORT_A:  b = port_a_irq_base;
      PER_COMP:    b = comparator_irq_base;
      PER_ADC:     b = converter_irq_base;
      PER_TMR_D0:  b = timer_d_type0_irq_base;
      PER_SPI_D:   b = serial_periph_d_vector;
      PER_USART_D: b = serial_d_irq_base;
      PER_PORT_F:  b = port_f_irq_base;
      PER_TMR_F0:  b = timer_f_type0_irq_base;
      default:     b = port_c_irq_base;
    endcase
    return b;
  endfunction

  // single-entry peripherals take their entry as is
  function automatic logic [MAP_W-1:0] src_vec(mlic_src_cfg_t c);
    logic single;
    single = (c.periph == PER_SPI_C) || (c.periph == PER_SPI_D);
    if (single) begin
      return periph_base(c.periph);
    end
    return periph_base(c.periph) + MAP_W'(c.offset);
  endfunction

  // word address out; relocation never touches the reset entry
  function automatic logic [VEC_W-1:0] place(logic [MAP_W-1:0] v,
                                             logic boot);
    logic [VEC_W-1:0] w;
    w = {{(VEC_W-MAP_W){1'b0}}, v};
    if (boot) begin
      w = w + BOOT_BASE;
    end
    return w;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic              irq_q;
  mlic_grant_t       grant_q;
  logic [IDX_W-1:0]  grant_idx_q;
  logic [NSRC-1:0]   ack_src_q;
  logic [2:0]        act_q;
  logic              nmi_act_q;
  logic              nmi_pend_q;
  logic              osc_prev_q;
  logic [IDX_W-1:0]  rr_ptr_q;
  logic              taken;

  assign taken = ack_in && irq_q;

  // ---------------------------------------------------------------
  // selection
  // ---------------------------------------------------------------
  logic [2:0]       lvl_ok;
  logic [2:0]       found;
  logic [IDX_W-1:0] best [NUM_LVL];
  logic [MAP_W-1:0] bestv [NUM_LVL];
  logic             sel_valid;
  mlic_grant_t      sel_grant;
  logic [IDX_W-1:0] sel_idx;
  logic             rr_found;
  logic [IDX_W-1:0] rr_idx;

  always_comb begin
    // a level runs only above every level now in service
    lvl_ok[2] = level_en_in[2] && !act_q[2];
    lvl_ok[1] = level_en_in[1] && !(|act_q[2:1]);
    lvl_ok[0] = level_en_in[0] && !(|act_q);
    if (nmi_act_q) begin
      lvl_ok = 3'h0;
    end
    for (int l = 0; l < NUM_LVL; l++) begin
      found[l] = 1'b0;
      best[l]  = '0;
      bestv[l] = '1;
    end
    for (int i = 0; i < NSRC; i++) begin
      for (int l = 0; l < NUM_LVL; l++) begin
        if (src_req_in[i] && src_cfg_in[i].level == 2'(l) &&
            (!found[l] || src_vec(src_cfg_in[i]) < bestv[l])) begin
          found[l] = 1'b1;
          best[l]  = IDX_W'(i);
          bestv[l] = src_vec(src_cfg_in[i]);
        end
      end
    end
    // rotation starts just past the last low grant, so none starves
    rr_found = 1'b0;
    rr_idx   = '0;
    for (int k = 1; k <= NSRC; k++) begin
      if (!rr_found &&
          src_req_in[(int'(rr_ptr_q) + k) % NSRC] &&
          src_cfg_in[(int'(rr_ptr_q) + k) % NSRC].level == LVL_LOW) begin
        rr_found = 1'b1;
        rr_idx   = IDX_W'((int'(rr_ptr_q) + k) % NSRC);
      end
    end
    if (rr_en_in) begin
      best[0]  = rr_idx;
      bestv[0] = src_vec(src_cfg_in[rr_idx]);
    end
    sel_valid = 1'b0;
    sel_idx   = '0;
    sel_grant = '0;
    if (nmi_pend_q && !nmi_act_q) begin
      sel_valid      = 1'b1;
      sel_grant.nmi  = 1'b1;
      sel_grant.addr = place(osc_fail_vector, vec_boot_in);
    end else begin
      for (int l = 0; l < NUM_LVL; l++) begin
        if (found[l] && lvl_ok[l]) begin
          sel_valid       = 1'b1;
          sel_idx         = best[l];
          sel_grant.level = 2'(l);
          sel_grant.addr  = place(bestv[l], vec_boot_in);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // request to the core
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      irq_q       <= 1'b0;
      grant_q     <= '0;
      grant_idx_q <= '0;
    end else begin
      // drop for one cycle after a take so a stale grant never repeats
      irq_q       <= sel_valid && !taken;
      grant_q     <= sel_grant;
      grant_idx_q <= sel_idx;
    end
  end

  // ---------------------------------------------------------------
  // acknowledge back to the source
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      ack_src_q <= '0;
    end else begin
      ack_src_q <= '0;
      if (taken && !grant_q.nmi) begin
        ack_src_q[grant_idx_q] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // levels in service; a take in the reti cycle still sets its bit
  // ---------------------------------------------------------------
  logic [2:0] act_d;
  logic       nmi_act_d;

  always_comb begin
    act_d     = act_q;
    nmi_act_d = nmi_act_q;
    // a return closes the highest routine still open
    if (reti_in) begin
      if (nmi_act_q) begin
        nmi_act_d = 1'b0;
      end else if (act_q[2]) begin
        act_d[2] = 1'b0;
      end else if (act_q[1]) begin
        act_d[1] = 1'b0;
      end else begin
        act_d[0] = 1'b0;
      end
    end
    // applied after the return, so a take in that cycle wins
    if (taken) begin
      if (grant_q.nmi) begin
        nmi_act_d = 1'b1;
      end else if (grant_q.level != LVL_OFF) begin
        act_d[grant_q.level] = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // in-service registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      act_q     <= 3'h0;
      nmi_act_q <= 1'b0;
    end else begin
      act_q     <= act_d;
      nmi_act_q <= nmi_act_d;
    end
  end

  // ---------------------------------------------------------------
  // oscillator failure, caught on its rising edge
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      osc_prev_q <= 1'b0;
      nmi_pend_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_fail_in;
      // the detector runs on this clock, so no synchroniser
      // a new failure beats the clear of the last one
      if (osc_fail_in && !osc_prev_q) begin
        nmi_pend_q <= 1'b1;
      end else if (taken && grant_q.nmi) begin
        nmi_pend_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // round-robin pointer follows every low grant
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rr_ptr_q <= IDX_W'(NSRC - 1);
    end else if (taken && !grant_q.nmi && grant_q.level == LVL_LOW) begin
      rr_ptr_q <= grant_idx_q;
    end
  end

  assign irq_out     = irq_q;
  assign grant_out   = grant_q;
  assign ack_src_out = ack_src_q;
  assign active_out  = {nmi_act_q, act_q};

endmodule

// ### sim/mlic_assertions.sv
// port-level assertions for the interrupt controller
`timescale 1ns/1ps
module mlic_assertions #(
  parameter int                         NSRC      = 16,
  parameter logic [mlic_pkg::VEC_W-1:0] BOOT_BASE = mlic_pkg::BOOT_BASE_RST
) (
  input wire logic                    clock_in,
  input wire logic                    rst_n_in,
  input wire logic [NSRC-1:0]         src_req_in,
  input wire mlic_pkg::mlic_src_cfg_t src_cfg_in [NSRC],
  input wire logic [2:0]              level_en_in,
  input wire logic                    rr_en_in,
  input wire logic                    vec_boot_in,
  input wire logic                    osc_fail_in,
  input wire logic                    ack_in,
  input wire logic                    reti_in,
  input wire logic                    irq_out,
  input wire mlic_pkg::mlic_grant_t   grant_out,
  input wire logic [NSRC-1:0]         ack_src_out,
  input wire logic [3:0]              active_out
);
  import mlic_pkg::*;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  AST_ACK_DROPS_IRQ: assert property (ack_in && irq_out |=> !irq_out)
    else $error("request stays up after being taken");
  AST_ACK_SETS_LVL: assert property (
    ack_in && irq_out && !grant_out.nmi
    |=> ((active_out >> $past(grant_out.level)) & 4'h1) != 4'h0)
    else $error("taken level not marked in service");
  AST_NMI_ADDR: assert property (irq_out && grant_out.nmi |->
    grant_out.addr == {9'h0, osc_fail_vector} ||
    grant_out.addr == BOOT_BASE + {9'h0, osc_fail_vector})
    else $error("oscillator failure vector wrong");
  AST_NO_RESET_VEC: assert property (irq_out |-> grant_out.addr != '0)
    else $error("reset entry handed out");
  AST_ACKSRC_CAUSE: assert property (|ack_src_out |->
    $past(ack_in && irq_out && !grant_out.nmi))
    else $error("source ack without a taken request");
  AST_ACKSRC_PULSE: assert property (|ack_src_out |->
    $onehot(ack_src_out) ##1 ack_src_out == '0)
    else $error("source ack not a one-hot pulse");
  AST_LEVEL_BLOCK: assert property (irq_out && !grant_out.nmi |->
    !active_out[3] && grant_out.level != LVL_OFF &&
    (active_out[2:0] >> grant_out.level) == 3'h0)
    else $error("grant at or below an active level");
  AST_LEVEL_EN: assert property (irq_out && !grant_out.nmi |->
    (($past(level_en_in) >> grant_out.level) & 3'h1) != 3'h0)
    else $error("grant on a disabled level");
  AST_NMI_LATENCY: assert property (
    $rose(osc_fail_in) && active_out == 4'h0
    |-> ##[1:3] irq_out && grant_out.nmi)
    else $error("oscillator failure not offered in time");
  AST_RETI_NMI: assert property (reti_in && !ack_in && active_out[3]
    |=> !active_out[3])
    else $error("return did not close nmi service");
endmodule

bind mlic_top mlic_assertions #(.NSRC(NSRC), .BOOT_BASE(BOOT_BASE))
  mlic_assertions_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .src_req_in(src_req_in), .src_cfg_in(src_cfg_in),
  .level_en_in(level_en_in), .rr_en_in(rr_en_in),
  .vec_boot_in(vec_boot_in), .osc_fail_in(osc_fail_in), .ack_in(ack_in),
  .reti_in(reti_in), .irq_out(irq_out), .grant_out(grant_out),
  .ack_src_out(ack_src_out), .active_out(active_out));

// ### sim/mlic_core_model.sv
// core stand-in: takes each offered request after a chosen wait
`timescale 1ns/1ps
module mlic_core_model (
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       irq_in,
  input  wire logic [1:0] wait_in,
  output logic            ack_out
);
  logic [1:0] cnt_q;
  // falling edge launch keeps ack steady across the sampling edge
  always_ff @(negedge clock_in) begin
    if (!rst_n_in || ack_out || !irq_in) begin
      ack_out <= 1'b0;
      cnt_q   <= 2'h0;
    end else if (cnt_q == wait_in) begin
      ack_out <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
endmodule

// ### sim/tb_mlic_top.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module tb_mlic_top;
  import mlic_pkg::*;
  localparam int NSRC = 16;
  localparam logic [MAP_W-1:0] BASES [23] = '{port_c_irq_base,
    port_r_irq_base, real_time_irq_base, two_wire_c_irq_base,
    timer_c_type0_irq_base, timer_c_type1_irq_base, serial_periph_c_vector,
    serial_c_irq_base, nonvolatile_irq_base, port_b_irq_base,
    port_e_irq_base, two_wire_e_irq_base, timer_e_type0_irq_base,
    serial_e_irq_base, port_d_irq_base, port_a_irq_base,
    comparator_irq_base, converter_irq_base, timer_d_type0_irq_base,
    serial_periph_d_vector, serial_d_irq_base, port_f_irq_base,
    timer_f_type0_irq_base};
  logic            clock_in = 1'b0;
  logic            rst_n_in, rr, boot, osc, ack, reti, irq;
  logic [NSRC-1:0] want, served, req, ack_src;
  mlic_src_cfg_t   cfg [NSRC];
  logic [2:0]      len;
  logic [1:0]      hold;
  logic [3:0]      act, ofs;
  mlic_grant_t     grant;
  logic [VEC_W:0]  expq [$];
  logic [NSRC+3:0] ackq [$];
  logic            post = 1'b0;
  int              fails = 0, n_checks = 0, taken = 0, seed = 32'h0d5c;

  mlic_top #(.NSRC(NSRC)) mlic_top_i (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .src_req_in(req), .src_cfg_in(cfg),
    .level_en_in(len), .rr_en_in(rr), .vec_boot_in(boot),
    .osc_fail_in(osc), .ack_in(ack), .reti_in(reti), .irq_out(irq),
    .grant_out(grant), .ack_src_out(ack_src), .active_out(act));
  mlic_core_model mlic_core_model_i (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .irq_in(irq), .wait_in(hold), .ack_out(ack));

  initial forever #2.5 clock_in = ~clock_in;
  // sources drop their request in the cycle of their ack pulse
  assign req = want & ~served & ~ack_src;
  always @(posedge clock_in) served <= (served | ack_src) & want;

  task automatic cmp_vec(input logic [VEC_W:0] e, input logic [VEC_W:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic cmp_ack(input logic [NSRC+3:0] e,
                         input logic [NSRC+3:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic note(input logic [VEC_W:0] v, input logic [NSRC+3:0] a);
    expq.push_back(v);
    ackq.push_back(a);
  endtask

  always @(posedge clock_in) begin
    // source ack and in-service bits show one edge after a take
    if (rst_n_in && post) begin
      if (ackq.size() == 0) cmp_ack('1, {ack_src, act});
      else cmp_ack(ackq.pop_front(), {ack_src, act});
    end
    post = rst_n_in && ack && irq;
    if (post) begin
      taken++;
      if (expq.size() == 0) cmp_vec('1, {grant.nmi, grant.addr});
      else cmp_vec(expq.pop_front(), {grant.nmi, grant.addr});
    end
  end

  task automatic cfg_src(input int i, input logic [1:0] l, input int p,
                         input logic [3:0] o);
    cfg[i] = '{l, mlic_periph_t'(p), o};
  endtask

  function automatic logic [VEC_W:0] vec(input int p, input logic [3:0] o);
    logic [MAP_W-1:0] a;
    a = (p == PER_SPI_C || p == PER_SPI_D) ? BASES[p] : BASES[p] + o;
    return {1'b0, boot ? BOOT_BASE_RST + VEC_W'(a) : VEC_W'(a)};
  endfunction

  task automatic wait_n(input int n);
    for (int k = 0; k < 200 && taken < n; k++) @(negedge clock_in);
    if (taken < n) fails++;
  endtask

  task automatic retire();
    @(negedge clock_in);
    reti = 1'b1;
    @(negedge clock_in);
    reti = 1'b0;
  endtask

  task automatic do_reset();
    rst_n_in = 1'b0;
    repeat (20) @(negedge clock_in);
    rst_n_in = 1'b1;
    @(negedge clock_in);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    rst_n_in = 1'b0;
    {want, rr, boot, osc, reti, hold} = '0;
    len = 3'h7;
    for (int i = 0; i < NSRC; i++) cfg_src(i, LVL_OFF, 0, 4'h0);
    do_reset();
    for (int p = 0; p < 23; p++) begin
      @(negedge clock_in);
      ofs = 4'($random(seed) & 3);
      hold = 2'($random(seed));
      boot = p[0];
      cfg_src(0, LVL_LOW, p, ofs);
      note(vec(p, ofs), 20'h00011);
      want = 16'h1;
      wait_n(taken + 1);
      want = '0;
      retire();
    end
    boot = 1'b0;
    cfg_src(1, LVL_LOW, PER_PORT_B, 4'h2);
    cfg_src(2, LVL_MED, PER_TMR_C1, 4'h1);
    cfg_src(3, LVL_HIGH, PER_ADC, 4'h3);
    note(vec(PER_PORT_B, 4'h2), 20'h00021);
    want = 16'h2;
    wait_n(taken + 1);
    note(vec(PER_TMR_C1, 4'h1), 20'h00043);
    want = 16'h6;
    wait_n(taken + 1);
    note(vec(PER_ADC, 4'h3), 20'h00087);
    want = 16'he;
    wait_n(taken + 1);
    // enables off: the oscillator failure must still get through
    len = 3'h0;
    note({1'b1, 9'h0, osc_fail_vector}, 20'h0000f);
    osc = 1'b1;
    wait_n(taken + 1);
    want = '0;
    repeat (4) retire();
    {osc, len} = {1'b0, 3'h7};
    for (int m = 0; m < 2; m++) begin
      do_reset();
      rr = m[0];
      cfg_src(3, LVL_LOW, PER_PORT_C, 4'h0);
      cfg_src(4, LVL_LOW, PER_PORT_D, 4'h0);
      cfg_src(5, LVL_LOW, PER_PORT_C, 4'h2);
      note(vec(PER_PORT_C, 4'h0), 20'h00081);
      note(m ? vec(PER_PORT_D, 0) : vec(PER_PORT_C, 2),
           m ? 20'h00101 : 20'h00201);
      note(m ? vec(PER_PORT_C, 2) : vec(PER_PORT_D, 0),
           m ? 20'h00201 : 20'h00101);
      want = 16'h38;
      repeat (3) begin
        wait_n(taken + 1);
        retire();
      end
      want = '0;
    end
    // idle controller, relocated map: failure offered within three edges
    boot = 1'b1;
    note({1'b1, BOOT_BASE_RST + VEC_W'(osc_fail_vector)}, 20'h00008);
    osc = 1'b1;
    wait_n(taken + 1);
    retire();
    if (expq.size() != 0 || ackq.size() != 0) fails++;
    test_done();
  end

  initial begin
    #20000;
    fails++;
    test_done();
  end
endmodule
